// ==== design/parallel_master_bus_cycle_engine.sv ====
// Master bus cycle engine for an 8/16-bit parallel port: address phases,
// wait states, strobes, chip selects and address stepping.
// Assumes config inputs are held stable while busy is high.
//
// Summary of operation
// - Step field 10 decrements, 01 increments, 00 keeps the address.
// - Address moves by exactly one, after the transfer ends and busy drops.
// - Top bits step only while they act as address, not chip select.
// - Every wait state lasts one clock cycle.
// - Setup field sets data setup cycles before the active strobe.
// - In multiplexed modes the setup field stretches the address period.
// - Strobe wait field sets the active strobe length.
// - Strobe field zero: one setup, one write hold, no read hold.
// - Hold field sets data hold cycles after the active strobe.
// - Multiplex field picks demux, partial, full 8-pin or full 16-pin.
// - Demux: address on address pins, data on 16 or 8 data pins.
// - Address pins 15 and 14 withheld when used as chip selects.
// - Partial: low address byte on data 7:0, high on address 15:8.
// - Partial: address pin 0 is low latch strobe, three extra cycles minimum.
// - Partial, strobe field nonzero: low latch longer by setup count.
// - Full 8-pin: low byte with low latch, then high byte with high latch.
// - Full 8-pin: address phases add at least six cycles.
// - Full modes: address bits 15/14 forced zero when chip selects enabled.
// - Full 16-pin needs 16-bit data; both latches together, three cycles minimum.
// - Full modes, strobe field nonzero: both latches longer by setup count.
// - Strobe mode 10 separate strobes; 11 direction plus enable strobe.
// - Requests made while busy are ignored.
`default_nettype none
`include "pmb_cfg.svh"
module parallel_master_bus_cycle_engine
    import pmb_pkg::*;
(
    // Clock and reset
    input wire logic         sys_clk,
    input wire logic         rst_n,
    // Configuration
    input wire logic  [12:0] mode_register,
    input wire logic  [1:0]  address_multiplex_field,
    input wire logic  [1:0]  strobe_mode,
    input wire logic  [1:0]  cs_func,
    // Address register
    input wire logic         addr_load,
    input wire logic  [15:0] addr_wdata,
    output logic      [15:0] bus_address_register,
    // Transfer requests
    input wire logic         req_valid,
    input wire logic         req_write,
    input wire logic  [15:0] req_wdata,
    output logic             busy,
    // Read data
    output logic             rd_valid,
    output logic      [15:0] rd_data,
    input wire logic         rd_ready,
    // Pins
    output logic      [15:0] address_pins,
    output logic      [15:0] address_pins_oe,
    input wire logic  [15:0] data_pins_in,
    output logic      [15:0] data_pins_out,
    output logic      [15:0] data_pins_oe,
    output logic             chip_select_1,
    output logic             chip_select_2,
    output logic             read_strobe,
    output logic             write_strobe,
    output logic             low_address_latch_strobe,
    output logic             high_address_latch_strobe
);
    logic [15:0] din_s1;
    logic [15:0] din_s2;
    phase_t      state;
    phase_t      next_state;
    count_t      cnt;
    count_t      next_cnt;
    logic        hi_phase;
    logic        next_hi;
    logic        op_write;
    logic        next_wr;
    word_t       op_wdata;
    word_t       stepped;
    word_t       pa;
    logic        accept;
    logic        done;
    logic [1:0]  step;
    logic [1:0]  setup_f;
    logic [3:0]  strb_f;
    logic [1:0]  hold_f;
    logic        wide;
    logic        short_cfg;
    logic [1:0]  mux;
    logic        muxed;
    logic        cs1_en;
    logic        cs2_en;
    logic [2:0]  latch_len;
    count_t      setup_len;
    count_t      strb_len;
    count_t      hold_len;
    logic        next_busy;
    logic [15:0] next_ap;
    logic [15:0] next_ap_oe;
    logic [15:0] next_dout;
    logic [15:0] next_doe;
    logic        next_rs;
    logic        next_ws;
    logic        next_all;
    logic        next_alh;
    logic        active;
    logic [1:0]  rd_pend;

    pmb_stream_if #(.W(16)) rd_in ();
    pmb_stream_if #(.W(16)) rd_out ();

    // Pin inputs pass two flops
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            din_s1 <= 16'h0000;
            din_s2 <= 16'h0000;
        end else begin
            din_s1 <= data_pins_in;
            din_s2 <= din_s1;
        end
    end

    assign step      = mode_register[`STEP_HI:`STEP_LO];
    assign setup_f   = mode_register[`SETUP_HI:`SETUP_LO];
    assign strb_f    = mode_register[`STRB_HI:`STRB_LO];
    assign hold_f    = mode_register[`HOLD_HI:`HOLD_LO];
    assign wide      = mode_register[`WIDE_BIT];
    assign short_cfg = strb_f == 4'h0;
    // 16-pin full mode falls back to 8-pin full mode with 8-bit data
    assign mux    = (address_multiplex_field == `MUX_FULL16 && !wide) ? `MUX_FULL8
                  : address_multiplex_field;
    assign muxed  = mux != `MUX_DEMUX;
    assign cs2_en = cs_func == `CSF_BOTH || cs_func == `CSF_CS2;
    assign cs1_en = cs_func == `CSF_BOTH;

    // Phase lengths in clock cycles
    assign latch_len = 3'h1 + (short_cfg ? 3'h0 : {1'b0, setup_f});
    assign setup_len = (muxed || short_cfg) ? 5'h01 : {3'h0, setup_f} + 5'h01;
    assign strb_len  = {1'b0, strb_f} + 5'h01;
    assign hold_len  = short_cfg ? {4'h0, op_write} : {3'h0, hold_f} + 5'h01;

    function automatic count_t phase_len(phase_t s);
        case (s)
            LATCH:   return {2'h0, latch_len};
            LGAP:    return `LATCH_GAP;
            SETUP:   return setup_len;
            STROBE:  return strb_len;
            HOLD:    return hold_len;
            default: return 5'h01;
        endcase
    endfunction : phase_len

    function automatic logic is_last(phase_t s, count_t c);
        return (s == HOLD && c == 5'h00) || (s == STROBE && c == 5'h00 && hold_len == 5'h00);
    endfunction : is_last

    // Reads also need room in the buffer and no read word in flight
    assign accept = state == IDLE && req_valid
                  && (req_write || (rd_in.ready && rd_pend == 2'h0));
    assign done   = state != IDLE && next_state == IDLE;

    always_comb begin
        next_state = state;
        next_hi    = hi_phase;
        case (state)
            IDLE: begin
                next_hi = 1'b0;
                if (accept) next_state = muxed ? LATCH : SETUP;
            end
            LATCH: begin
                if (cnt == 5'h00) next_state = LGAP;
            end
            LGAP: begin
                if (cnt == 5'h00) begin
                    if (mux == `MUX_FULL8 && !hi_phase) begin
                        next_state = LATCH;
                        next_hi    = 1'b1;
                    end else begin
                        next_state = SETUP;
                    end
                end
            end
            SETUP: begin
                if (cnt == 5'h00) next_state = STROBE;
            end
            STROBE: begin
                if (cnt == 5'h00) next_state = (hold_len == 5'h00) ? IDLE : HOLD;
            end
            HOLD: begin
                if (cnt == 5'h00) next_state = IDLE;
            end
            default: next_state = IDLE;
        endcase
        if (next_state != state || next_hi != hi_phase) next_cnt = phase_len(next_state) - 5'h01;
        else next_cnt = cnt - 5'h01;
    end

    assign next_wr   = accept ? req_write : op_write;
    assign next_busy = next_state != IDLE && !is_last(next_state, next_cnt);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state    <= IDLE;
            cnt      <= 5'h00;
            hi_phase <= 1'b0;
            busy     <= 1'b0;
        end else begin
            state    <= next_state;
            cnt      <= next_cnt;
            hi_phase <= next_hi;
            busy     <= next_busy;
        end
    end

    // Request capture; ignored unless idle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            op_write <= 1'b0;
            op_wdata <= 16'h0000;
        end else if (accept) begin
            op_write <= req_write;
            op_wdata <= req_wdata;
        end
    end

    pmb_addr_stepper u_stepper (
        .addr      (bus_address_register),
        .step      (step),
        .cs_func   (cs_func),
        .next_addr (stepped)
    );

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) bus_address_register <= `ADDR_RST;
        else if (done) bus_address_register <= stepped;
        else if (addr_load && state == IDLE) bus_address_register <= addr_wdata;
    end

    // Presented address; chip select bits zero in full modes
    always_comb begin
        pa = bus_address_register;
        if (mux == `MUX_FULL8 || mux == `MUX_FULL16) begin
            if (cs2_en) pa[15] = 1'b0;
            if (cs1_en) pa[14] = 1'b0;
        end
    end

    // Pin values for the coming cycle
    always_comb begin
        active     = next_state != IDLE;
        next_ap    = bus_address_register;
        next_dout  = 16'h0000;
        next_doe   = 16'h0000;
        next_all   = 1'b0;
        next_alh   = 1'b0;
        case (mux)
            `MUX_DEMUX: next_ap_oe = 16'hFFFF;
            `MUX_PART:  next_ap_oe = 16'hFF00;
            default:    next_ap_oe = 16'hC000;
        endcase
        if (cs2_en) next_ap_oe[15] = 1'b0;
        if (cs1_en) next_ap_oe[14] = 1'b0;
        if (next_state == LATCH || next_state == LGAP) begin
            next_doe = (mux == `MUX_FULL16) ? 16'hFFFF : 16'h00FF;
            if (mux == `MUX_FULL16) next_dout = pa;
            else if (next_hi) next_dout = {8'h00, pa[15:8]};
            else next_dout = {8'h00, pa[7:0]};
        end else if (active && next_wr) begin
            next_doe  = wide ? 16'hFFFF : 16'h00FF;
            next_dout = wide ? op_wdata : {8'h00, op_wdata[7:0]};
            if (accept) next_dout = wide ? req_wdata : {8'h00, req_wdata[7:0]};
        end
        if (next_state == LATCH) begin
            next_all = mux != `MUX_FULL8 || !next_hi;
            next_alh = mux == `MUX_FULL16 || (mux == `MUX_FULL8 && next_hi);
        end
        if (strobe_mode == `STRB_COMB) begin
            next_rs = active && !next_wr;
            next_ws = next_state == STROBE;
        end else begin
            next_rs = next_state == STROBE && !next_wr;
            next_ws = next_state == STROBE && next_wr;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            address_pins              <= 16'h0000;
            address_pins_oe           <= 16'h0000;
            data_pins_out             <= 16'h0000;
            data_pins_oe              <= 16'h0000;
            chip_select_1             <= 1'b0;
            chip_select_2             <= 1'b0;
            read_strobe               <= 1'b0;
            write_strobe              <= 1'b0;
            low_address_latch_strobe  <= 1'b0;
            high_address_latch_strobe <= 1'b0;
        end else begin
            address_pins              <= next_ap;
            address_pins_oe           <= next_ap_oe;
            data_pins_out             <= next_dout;
            data_pins_oe              <= next_doe;
            chip_select_1             <= active && cs1_en;
            chip_select_2             <= active && cs2_en;
            read_strobe               <= next_rs;
            write_strobe              <= next_ws;
            low_address_latch_strobe  <= next_all;
            high_address_latch_strobe <= next_alh;
        end
    end

    // Last strobe cycle's pins reach din_s2 two edges later
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) rd_pend <= 2'h0;
        else rd_pend <= {rd_pend[0], state == STROBE && cnt == 5'h00 && !op_write};
    end

    assign rd_in.valid = rd_pend[1];
    assign rd_in.data  = wide ? din_s2 : {8'h00, din_s2[7:0]};

    pmb_two_entry_buffer #(.W(16)) u_rd_buf (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .in_s    (rd_in),
        .out_s   (rd_out)
    );

    assign rd_valid     = rd_out.valid;
    assign rd_data      = rd_out.data;
    assign rd_out.ready = rd_ready;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_lat3;
        low_address_latch_strobe [*3] ##1 !low_address_latch_strobe;
    endsequence
    sequence s_nostrobe6;
        (!read_strobe && !write_strobe) [*6];
    endsequence

    property p_inc;
        done && step == `STEP_INC && cs_func == `CSF_NONE
            |=> bus_address_register == $past(bus_address_register) + 16'h0001;
    endproperty
    a_inc: assert property (p_inc) else $error("address did not increment");
    property p_keep;
        done && step == `STEP_NONE |=> $stable(bus_address_register);
    endproperty
    a_keep: assert property (p_keep) else $error("address moved without step");
    property p_cs_bits;
        done && cs_func == `CSF_BOTH |=> bus_address_register[15:14] == $past(bus_address_register[15:14]);
    endproperty
    a_cs_bits: assert property (p_cs_bits) else $error("chip select bits stepped");
    property p_busy_last;
        done |-> !busy;
    endproperty
    a_busy_last: assert property (p_busy_last) else $error("busy high in last cycle");
    property p_ignore;
        state != IDLE && req_valid |=> $stable(op_wdata) && $stable(op_write);
    endproperty
    a_ignore: assert property (p_ignore) else $error("request taken while busy");
    property p_strobe2;
        strb_f == 4'h1 && $rose(write_strobe)
            |-> write_strobe ##1 write_strobe ##1 !write_strobe;
    endproperty
    a_strobe2: assert property (p_strobe2) else $error("strobe length wrong");
    property p_lat_ext;
        mux == `MUX_PART && strb_f != 4'h0 && setup_f == 2'h2 && $rose(low_address_latch_strobe)
            |-> s_lat3;
    endproperty
    a_lat_ext: assert property (p_lat_ext) else $error("latch not extended");
    property p_part3;
        mux == `MUX_PART && strobe_mode == `STRB_SEP && $rose(low_address_latch_strobe)
            |-> (!read_strobe && !write_strobe) [*3];
    endproperty
    a_part3: assert property (p_part3) else $error("partial mux too short");
    property p_full6;
        mux == `MUX_FULL8 && strobe_mode == `STRB_SEP && $rose(low_address_latch_strobe)
            |-> s_nostrobe6;
    endproperty
    a_full6: assert property (p_full6) else $error("full mux too short");
    property p_full8_hi;
        mux == `MUX_FULL8 && $fell(low_address_latch_strobe) |-> ##[1:8] high_address_latch_strobe;
    endproperty
    a_full8_hi: assert property (p_full8_hi) else $error("no high latch phase");
    property p_full16;
        mux == `MUX_FULL16 |-> low_address_latch_strobe == high_address_latch_strobe;
    endproperty
    a_full16: assert property (p_full16) else $error("latches not together");
    property p_withhold;
        cs2_en && state != IDLE |-> !address_pins_oe[15];
    endproperty
    a_withhold: assert property (p_withhold) else $error("address 15 driven as address");
    property p_force0;
        mux == `MUX_FULL8 && cs2_en && high_address_latch_strobe |-> !data_pins_out[7];
    endproperty
    a_force0: assert property (p_force0) else $error("address 15 not forced zero");
endmodule : parallel_master_bus_cycle_engine
`default_nettype wire

// ==== design/pmb_addr_stepper.sv ====
// Next bus address after a completed transfer.
// Assumes chip select bits sit at the top of the address.
`default_nettype none
`include "pmb_cfg.svh"
module pmb_addr_stepper
    import pmb_pkg::*;
(
    input wire logic [15:0] addr,
    input wire logic [1:0]  step,
    input wire logic [1:0]  cs_func,
    output logic     [15:0] next_addr
);
    // Carry chain spans only the bits that act as address
    function automatic word_t step_addr(word_t a, logic [1:0] s, logic [1:0] csf);
        word_t m;
        word_t r;
        m = (csf == `CSF_BOTH) ? 16'h3FFF : (csf == `CSF_CS2) ? 16'h7FFF : 16'hFFFF;
        case (s)
            `STEP_INC: r = a + 16'h0001;
            `STEP_DEC: r = a - 16'h0001;
            default:   r = a;
        endcase
        return (r & m) | (a & ~m);
    endfunction : step_addr

    assign next_addr = step_addr(addr, step, cs_func);
endmodule : pmb_addr_stepper
`default_nettype wire

// ==== design/pmb_cfg.svh ====
// Offsets, field positions, codes and counts of the parallel bus cycle engine.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef PMB_CFG_SVH
`define PMB_CFG_SVH
// Field positions inside the mode register input
`define STEP_HI     12
`define STEP_LO     11
`define WIDE_BIT    10
`define SETUP_HI    7
`define SETUP_LO    6
`define STRB_HI     5
`define STRB_LO     2
`define HOLD_HI     1
`define HOLD_LO     0
// Address step codes
`define STEP_NONE   2'h0
`define STEP_INC    2'h1
`define STEP_DEC    2'h2
// Address multiplex codes
`define MUX_DEMUX   2'h0
`define MUX_PART    2'h1
`define MUX_FULL8   2'h2
`define MUX_FULL16  2'h3
// Strobe modes
`define STRB_SEP    2'h2
`define STRB_COMB   2'h3
// Chip select function codes
`define CSF_NONE    2'h0
`define CSF_CS2     2'h1
`define CSF_BOTH    2'h2
// Cycles that address stays on the pins after a latch strobe
`define LATCH_GAP   5'h02
`define ADDR_RST    16'h0000
`endif

// ==== design/pmb_pkg.sv ====
// Types shared by the parallel bus cycle engine modules.
// Assumes pmb_cfg.svh is reachable on the include path.
`default_nettype none
`include "pmb_cfg.svh"
package pmb_pkg;
    typedef enum logic [2:0] {IDLE, LATCH, LGAP, SETUP, STROBE, HOLD} phase_t;
    typedef logic [15:0] word_t;
    typedef logic [4:0]  count_t;
endpackage : pmb_pkg
`default_nettype wire

// ==== design/pmb_stream_if.sv ====
// Valid/ready word stream between engine, buffer and top ports.
// Assumes one clock domain shared by both ends.
`default_nettype none
interface pmb_stream_if #(parameter int W = 16);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : pmb_stream_if
`default_nettype wire

// ==== design/pmb_two_entry_buffer.sv ====
// Two-entry read data buffer with valid/ready on both sides.
// Assumes the filling side waits for ready before pushing.
`default_nettype none
module pmb_two_entry_buffer #(
    parameter int W = 16
) (
    input wire logic   sys_clk,
    input wire logic   rst_n,
    pmb_stream_if.snk  in_s,
    pmb_stream_if.src  out_s
);
    logic [W-1:0] slot [2];
    logic         wp;
    logic         rp;
    logic [1:0]   fill;
    logic         push;
    logic         pop;

    assign push        = in_s.valid && in_s.ready;
    assign pop         = out_s.valid && out_s.ready;
    assign in_s.ready  = fill != 2'h2;
    assign out_s.valid = fill != 2'h0;
    assign out_s.data  = slot[rp];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fill <= 2'h0;
            wp   <= 1'b0;
            rp   <= 1'b0;
        end else begin
            fill <= fill + {1'b0, push} - {1'b0, pop};
            if (push) wp <= ~wp;
            if (pop) rp <= ~rp;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            slot[0] <= '0;
            slot[1] <= '0;
        end else if (push) begin
            slot[wp] <= in_s.data;
        end
    end
endmodule : pmb_two_entry_buffer
`default_nettype wire

// ==== sim/pmb_mem_model.sv ====
// Partner memory of 16 words picked by address bits 3:0, active-high strobes.
// Assumes separate strobes on reads and the low latch strobe in mux modes.
`default_nettype none
module pmb_mem_model (
    // Clock and mode
    input  wire logic        sys_clk,
    input  wire logic        mux_on,
    // Engine pins
    input  wire logic [15:0] address_pins,
    input  wire logic [15:0] data_pins_out,
    input  wire logic        read_strobe,
    input  wire logic        write_strobe,
    input  wire logic        low_address_latch_strobe,
    output logic      [15:0] data_pins_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0]      mem [16];
    logic [3:0]       lat;
    logic             flip = 1'b0;
    wire  logic [3:0] a = mux_on ? lat : address_pins[3:0];
    // Released bus toggles so a stale word never passes for data
    assign data_pins_in = read_strobe ? mem[a] : {16{flip}} ^ 16'h5A5A;
    always @(posedge sys_clk) begin
        flip <= ~flip;
        if (low_address_latch_strobe) lat <= data_pins_out[3:0];
        if (write_strobe) mem[a] <= data_pins_out;
    end
endmodule : pmb_mem_model
`default_nettype wire

// ==== sim/tb.sv ====
// Self-checking bench for the parallel bus cycle engine.
// Assumes the engine, its buffer and pmb_mem_model are compiled first.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk, rst_n, addr_load, req_valid, req_write, rd_ready, wd, mon;
    logic        busy, rd_valid, chip_select_1, chip_select_2, read_strobe, write_strobe;
    logic        low_address_latch_strobe, high_address_latch_strobe;
    logic [1:0]  mx, sm, cs, st, su, hd, pcs;
    logic [3:0]  sb;
    logic [15:0] addr_wdata, req_wdata, data_pins_in, bus_address_register, rd_data;
    logic [15:0] address_pins, address_pins_oe, data_pins_out, data_pins_oe;
    logic [15:0] n_busy, n_wr, n_rd, n_ll, n_lh, lat_lo, lat_hi, pa, pd, aoe, doe;
    logic [15:0] mir [16];
    int          checks, n_fail;

    parallel_master_bus_cycle_engine dut_u (
        .sys_clk, .rst_n, .mode_register({st, wd, 2'h0, su, sb, hd}),
        .address_multiplex_field(mx), .strobe_mode(sm), .cs_func(cs),
        .addr_load, .addr_wdata, .bus_address_register, .req_valid, .req_write,
        .req_wdata, .busy, .rd_valid, .rd_data, .rd_ready, .address_pins,
        .address_pins_oe, .data_pins_in, .data_pins_out, .data_pins_oe,
        .chip_select_1, .chip_select_2, .read_strobe, .write_strobe,
        .low_address_latch_strobe, .high_address_latch_strobe);
    pmb_mem_model mem_u (
        .sys_clk, .mux_on(mx != 2'h0), .address_pins, .data_pins_out, .read_strobe,
        .write_strobe, .low_address_latch_strobe, .data_pins_in);

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // Pin monitor: strobe lengths and what the pins carry
    always @(posedge sys_clk) begin
        if (mon) begin
            n_busy <= n_busy + 16'(busy);
            n_wr <= n_wr + 16'(write_strobe);
            n_rd <= n_rd + 16'(read_strobe);
            n_ll <= n_ll + 16'(low_address_latch_strobe);
            n_lh <= n_lh + 16'(high_address_latch_strobe);
            if (low_address_latch_strobe) lat_lo <= data_pins_out;
            if (high_address_latch_strobe) lat_hi <= data_pins_out;
            if (read_strobe || write_strobe) begin
                {pa, pd, aoe, doe} <= {address_pins, data_pins_out, address_pins_oe, data_pins_oe};
                pcs <= {chip_select_2, chip_select_1};
            end
        end
    end

    task automatic report_and_stop;
        $display("Checks %0d errors %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick;
        @(posedge sys_clk);
        #1;
    endtask : tick

    task automatic guard(input int i, input int lim);
        if (i >= lim) begin
            n_fail++;
            report_and_stop;
        end
    endtask : guard

    task automatic cfg(input int a, b, c, d, e, f, g, h);
        {mx, sm, cs, st, wd, su, sb, hd} = {2'(a), 2'(b), 2'(c), 2'(d), 1'(e), 2'(f), 4'(g), 2'(h)};
    endtask : cfg

    task automatic pop(input logic [15:0] e);
        int i;
        for (i = 0; i < 20 && rd_valid !== 1'b1; i++) tick;
        guard(i, 20);
        chk(rd_data, e);
        rd_ready = 1'b1;
        tick;
        rd_ready = 1'b0;
        tick;
    endtask : pop

    task automatic run(input logic w, input logic [15:0] ad, d, input logic ok, pp);
        int          i, lat, eb, el;
        logic [15:0] m, nx, dm;
        m = cs == 2'h2 ? 16'h3FFF : cs == 2'h1 ? 16'h7FFF : 16'hFFFF;
        nx = st == 2'h1 ? ad + 16'h1 : st == 2'h2 ? ad - 16'h1 : ad;
        dm = wd ? 16'hFFFF : 16'h00FF;
        lat = mx == 0 ? 0 : (3 + (sb != 0 ? su : 0)) * (mx == 2 ? 2 : 1);
        eb = ok ? lat + (mx != 0 || sb == 0 ? 1 : su + 1) + sb + (sb == 0 ? w : hd + 1) : 0;
        el = ok && mx != 0 ? 1 + (sb != 0 ? su : 0) : 0;
        addr_load = 1'b1;
        addr_wdata = ad;
        tick;
        addr_load = 1'b0;
        {n_busy, n_wr, n_rd, n_ll, n_lh} = '0;
        mon = 1'b1;
        req_valid = 1'b1;
        req_write = w;
        req_wdata = d;
        tick;
        req_valid = 1'b0;
        tick;
        // Second request in mid-operation
        req_valid = ok;
        req_write = ~w;
        tick;
        req_valid = 1'b0;
        for (i = 0; i < 60 && busy !== 1'b0; i++) tick;
        guard(i, 60);
        tick;
        tick;
        mon = 1'b0;
        chk(n_busy, 16'(eb));
        chk(sm == 2'h3 || w ? n_wr : n_rd, ok ? 16'(sb) + 16'h1 : 16'h0);
        if (sm != 2'h3) chk(w ? n_rd : n_wr, 16'h0);
        chk(n_ll, 16'(el));
        chk(n_lh, mx[1] ? 16'(el) : 16'h0);
        chk(bus_address_register, ok ? (ad & ~m) | (nx & m) : ad);
        if (ok) begin
            chk(aoe & (mx == 2'h1 ? 16'h00FE : mx != 2'h0 ? 16'h3FFC : 16'h0), 16'h0);
            chk({14'h0, aoe[15:14] & ~m[15:14]}, 16'h0);
            chk({14'h0, pcs}, {14'h0, ~m[15:14]});
            chk(doe, w ? dm : 16'h0);
            if (w) chk(pd & dm, d & dm);
            if (mx == 2'h0) chk(pa & 16'h3FFF, ad & 16'h3FFF);
            if (mx == 2'h1) chk({2'h0, pa[13:8], lat_lo[7:0]}, ad & 16'h3FFF);
            if (mx == 2'h2) chk({lat_hi[7:0], lat_lo[7:0]}, ad & m);
            if (mx == 2'h3) chk(lat_lo, ad & m);
            if (w) mir[ad[3:0]] = d;
        end
        if (pp) pop(wd ? mir[ad[3:0]] : {8'h00, mir[ad[3:0]][7:0]});
    endtask : run

    initial begin
        {rst_n, addr_load, req_valid, req_write, rd_ready, mon} = '0;
        {addr_wdata, req_wdata} = '0;
        checks = 0;
        n_fail = 0;
        cfg(0, 2, 0, 1, 1, 0, 0, 0);
        repeat (12) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        chk(bus_address_register | address_pins_oe | data_pins_oe, 16'h0);
        chk(16'({busy, rd_valid, read_strobe, write_strobe, chip_select_2}), 16'h0);
        run(1'b1, 16'hFFFF, 16'h1234, 1'b1, 1'b0);
        cfg(0, 2, 2, 2, 1, 2, 3, 1);
        run(1'b1, 16'hC000, 16'hABCD, 1'b1, 1'b0);
        run(1'b0, 16'hC000, 16'h0000, 1'b1, 1'b1);
        cfg(0, 2, 1, 1, 1, 0, 0, 0);
        run(1'b1, 16'hFFFF, 16'h5A5A, 1'b1, 1'b0);
        cfg(1, 2, 2, 0, 1, 2, 3, 0);
        run(1'b1, 16'h1234, 16'h0F0F, 1'b1, 1'b0);
        cfg(2, 2, 2, 1, 1, 1, 2, 2);
        run(1'b1, 16'hF2A5, 16'h1357, 1'b1, 1'b0);
        cfg(3, 3, 1, 1, 1, 3, 1, 0);
        run(1'b1, 16'hB0B6, 16'h2468, 1'b1, 1'b0);
        cfg(2, 2, 0, 0, 1, 3, 0, 3);
        run(1'b1, 16'h0007, 16'h7777, 1'b1, 1'b0);
        cfg(0, 2, 2, 0, 1, 0, 3, 0);
        run(1'b0, 16'h0005, 16'h0000, 1'b1, 1'b1);
        cfg(1, 2, 2, 0, 0, 1, 4, 1);
        run(1'b0, 16'h0006, 16'h0000, 1'b1, 1'b1);
        cfg(0, 2, 0, 0, 1, 0, 0, 0);
        run(1'b0, 16'h0007, 16'h0000, 1'b1, 1'b1);
        cfg(0, 2, 2, 0, 1, 0, 3, 0);
        run(1'b0, 16'h0004, 16'h0000, 1'b1, 1'b0);
        run(1'b0, 16'h0004, 16'h0000, 1'b1, 1'b0);
        run(1'b0, 16'h0004, 16'h0000, 1'b0, 1'b0);
        pop(16'h0F0F);
        pop(16'h0F0F);
        chk(16'(rd_valid), 16'h0);
        report_and_stop;
    end
endmodule : tb
`default_nettype wire
